// File: design/ecct_params.svh
// register map, command codes and timing counts of the counter bank
`ifndef ECCT_PARAMS_SVH
`define ECCT_PARAMS_SVH
// bank shape
`define ECCT_NCH        8
`define ECCT_CW         32
`define ECCT_AW         8
// register indices; byte address is four times the index
`define ECCT_IDX_LSB    2
`define ECCT_IDX_HI     4
`define ECCT_IDX_DATA3  3'h3
`define ECCT_IDX_SEL    3'h4
`define ECCT_IDX_CMD    3'h5
`define ECCT_IDX_LFS    3'h6
`define ECCT_IDX_STAT   3'h7
// command register fields
`define ECCT_CODE_HI    7
`define ECCT_CODE_LO    4
`define ECCT_ARG_HI     1
// command codes
`define ECCT_OP_CLEAR   4'h0
`define ECCT_OP_LOAD    4'h1
`define ECCT_OP_DIR     4'h2
`define ECCT_OP_GATE    4'h3
`define ECCT_OP_RUN     4'h4
`define ECCT_OP_LATCH   4'h5
`define ECCT_OP_SRC     4'h6
`define ECCT_OP_RELOAD  4'h7
`define ECCT_OP_OUT     4'h8
`define ECCT_OP_RESET   4'hF
// clock source codes
`define ECCT_SRC_EXT    2'h0
`define ECCT_SRC_FAST   2'h2
`define ECCT_SRC_SLOW   2'h3
// lines handed back to general i/o by the line function select
`define ECCT_HIGH_LINES 8'hF0
`define ECCT_LFS_RESET  1'h0
// bus answers
`define ECCT_RESP_OKAY  2'h0
`define ECCT_RESP_SLVERR 2'h2
// timing: system clock and the two internal counting rates
`define ECCT_CLK_HZ     100000000
`define ECCT_FAST_HZ    50000000
`define ECCT_SLOW_HZ    1000000
`define ECCT_DIV_FAST   (`ECCT_CLK_HZ / `ECCT_FAST_HZ)
`define ECCT_DIV_SLOW   (`ECCT_CLK_HZ / `ECCT_SLOW_HZ)
`endif

// File: design/ecct_pkg.sv
// types shared by the counter bank and its channels
package ecct_pkg;
  // per-counter settings
  typedef struct packed {
    logic       up;
    logic       run;
    logic       reload_en;
    logic [1:0] src;
    logic       out_en;
    logic       out_pol;
  } ecct_cfg_t;
  // one command aimed at one channel
  typedef struct packed {
    logic       valid;
    logic [3:0] code;
    logic [1:0] arg;
  } ecct_cmd_t;
  // drive of the shared port c lines
  typedef struct packed {
    logic [7:0] oe;
    logic [7:0] dout;
  } ecct_pins_t;
endpackage

// File: design/ecct_channel.sv
// one counter/timer channel: count, reload value, settings, zero pulse
`timescale 1ns/100ps
`include "ecct_params.svh"
module ecct_channel (
  // clock and reset
  input  wire logic                  clock,
  input  wire logic                  resetn,
  // command and data word from the register window
  input  ecct_pkg::ecct_cmd_t        cmd,
  input  wire logic [`ECCT_CW-1:0]   data_word,
  // counting clock candidates, one-cycle enables
  input  wire logic                  ext_fall,
  input  wire logic                  tick_fast,
  input  wire logic                  tick_slow,
  // channel state
  output ecct_pkg::ecct_cfg_t        cfg,
  output logic [`ECCT_CW-1:0]        count,
  output logic                       pulse
);
  import ecct_pkg::*;

  // =====================================================
  // counting clock and end-of-count detect
  ecct_cfg_t           next_cfg;
  logic [`ECCT_CW-1:0] next_count;
  logic [`ECCT_CW-1:0] reload;
  logic [`ECCT_CW-1:0] next_reload;
  wire tick = (cfg.src == `ECCT_SRC_EXT  & ext_fall)  |
              (cfg.src == `ECCT_SRC_FAST & tick_fast) |
              (cfg.src == `ECCT_SRC_SLOW & tick_slow);
  wire step = cfg.run & tick;
  wire at_one = count == 32'h0000_0001;
  wire zero_hit = step & ~cfg.up & at_one & ~cmd.valid;
  wire is_reset = cmd.valid & cmd.code == `ECCT_OP_RESET;

  // =====================================================
  // command decode; a command wins over a count step that cycle
  always_comb begin
    next_cfg = cfg;
    next_count = count;
    next_reload = reload;
    if (cmd.valid) begin
      unique case (cmd.code)
        `ECCT_OP_CLEAR:  next_count = cfg.up ? '0 : reload;
        `ECCT_OP_LOAD: begin
          next_count = data_word;
          next_reload = data_word;
        end
        `ECCT_OP_DIR:    next_cfg.up = cmd.arg[0];
        `ECCT_OP_RUN:    next_cfg.run = cmd.arg[0];
        `ECCT_OP_SRC:    next_cfg.src = cmd.arg;
        `ECCT_OP_RELOAD: next_cfg.reload_en = cmd.arg[0];
        `ECCT_OP_OUT: begin
          next_cfg.out_en = cmd.arg[`ECCT_ARG_HI];
          if (cmd.arg[`ECCT_ARG_HI]) begin
            next_cfg.out_pol = cmd.arg[0];
          end
        end
        `ECCT_OP_RESET: begin
          next_cfg = '0;
          next_count = '0;
          next_reload = '0;
        end
        // gate is accepted and does nothing, as do the spare codes
        default: next_count = count;
      endcase
    end else if (step) begin
      if (cfg.up) begin
        next_count = count + 32'h0000_0001;
      end else if (at_one & cfg.reload_en) begin
        next_count = reload;
      end else if (at_one) begin
        next_count = '0;
        next_cfg.run = 1'b0;
      end else if (count != '0) begin
        next_count = count - 32'h0000_0001;
      end
    end
  end

  // =====================================================
  // state registers; pulse spans one counting-clock period
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cfg <= '0;
      count <= '0;
      reload <= '0;
      pulse <= 1'b0;
    end else begin
      cfg <= next_cfg;
      count <= next_count;
      reload <= next_reload;
      if (is_reset) begin
        pulse <= 1'b0;
      end else if (tick) begin
        pulse <= zero_hit;
      end
    end
  end

  // =====================================================
  // checks
  AST_CLEAR_DOWN: assert property (@(posedge clock) disable iff (!resetn)
    cmd.valid & cmd.code == `ECCT_OP_CLEAR & ~cfg.up
    |=> count == $past(reload))
    else $error("clear while counting down missed reload value");
  AST_LOAD: assert property (@(posedge clock) disable iff (!resetn)
    cmd.valid & cmd.code == `ECCT_OP_LOAD |=> count == $past(data_word))
    else $error("load did not take the data word");
  AST_HALT: assert property (@(posedge clock) disable iff (!resetn)
    ~cmd.valid & zero_hit & ~cfg.reload_en |=> count == '0 && !cfg.run)
    else $error("down count without reload did not stop at zero");
  AST_HOLD: assert property (@(posedge clock) disable iff (!resetn)
    ~cmd.valid & ~cfg.run |=> $stable(count))
    else $error("stopped counter changed its count");
endmodule

// File: design/ecct_bank.sv
// eight-channel counter/timer bank with axi4-lite register window
`timescale 1ns/100ps
`include "ecct_params.svh"
// Overview of operation
// - eight independent 32-bit counters, each with its own settings
// - select at index 4, data word at indices 0-3, commands at index 5
// - clear: up counter to zero, down counter to reload value, keeps running
// - load copies the data word into the selected count
// - direction command: argument bit zero one counts up, zero down
// - gate command is accepted and changes nothing
// - enable command starts or stops counting per argument bit zero
// - latch copies the live count into the readable data word
// - source: 00 external active-low pin, 10 fast, 11 slow internal
// - external clock source forces the counter's line to input
// - input role beats output role on the shared line
// - down count at one reloads if auto-reload, else steps to zero, halts
// - output command enables output by argument bit one; down count only
// - output enable drives the line unless it is the external clock or lent to general i/o
// - polarity zero idles high pulsing low at zero, one the reverse
// - reset clears selected counter, or all when argument bit zero set
// - line function select hands lines 7-4 to general i/o when one
module ecct_bank (
  // clock and reset
  input  wire logic                 clock,
  input  wire logic                 resetn,
  // axi4-lite write address and data
  input  wire logic [`ECCT_AW-1:0]  s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  // axi4-lite write response
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  // axi4-lite read
  input  wire logic [`ECCT_AW-1:0]  s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  // shared port c lines
  input  wire logic [`ECCT_NCH-1:0] ctr_pin_in,
  output ecct_pkg::ecct_pins_t      pin_drive
);
  import ecct_pkg::*;

  // =====================================================
  // write channel: address and data taken in either order
  logic                aw_held;
  logic                w_held;
  logic [`ECCT_AW-1:0] aw_addr;
  logic [31:0]         w_data;
  logic [3:0]          w_strb;
  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take = s_axi_wvalid & s_axi_wready;
  wire do_write = aw_held & w_held & ~s_axi_bvalid;
  wire next_aw_held = aw_take | (aw_held & ~do_write);
  wire next_w_held = w_take | (w_held & ~do_write);
  wire next_bvalid = do_write | (s_axi_bvalid & ~s_axi_bready);
  wire [2:0] w_idx = aw_addr[`ECCT_IDX_HI:`ECCT_IDX_LSB];
  wire w_mapped = aw_addr[`ECCT_AW-1:`ECCT_IDX_HI+1] == '0;
  wire wr_en = do_write & w_mapped & w_strb[0];

  // each ready only while its own beat is not held and no answer waits, so one write at a time
  // bresp is taken at execution and stands until bready
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `ECCT_RESP_OKAY;
    end else begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      s_axi_awready <= ~next_aw_held & ~next_bvalid;
      s_axi_wready <= ~next_w_held & ~next_bvalid;
      s_axi_bvalid <= next_bvalid;
      if (do_write) begin
        s_axi_bresp <= w_mapped ? `ECCT_RESP_OKAY : `ECCT_RESP_SLVERR;
      end
    end
  end

  // payload capture
  // kept apart so that either beat may arrive first
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
    end else begin
      if (aw_take) begin
        aw_addr <= s_axi_awaddr;
      end
      if (w_take) begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
    end
  end

  // =====================================================
  // command decode
  logic [7:0]          sel;
  logic                lfs;
  logic [`ECCT_CW-1:0] data_word;
  logic [`ECCT_CW-1:0] latch;
  ecct_cfg_t           ch_cfg [`ECCT_NCH];
  logic [`ECCT_CW-1:0] ch_count [`ECCT_NCH];
  logic [`ECCT_NCH-1:0] ch_pulse;
  logic [`ECCT_NCH-1:0] ch_run;
  wire cmd_fire = wr_en & w_idx == `ECCT_IDX_CMD;
  wire [3:0] cmd_code = w_data[`ECCT_CODE_HI:`ECCT_CODE_LO];
  wire [1:0] cmd_arg = w_data[`ECCT_ARG_HI:0];
  wire sel_ok = sel[7:3] == 5'h00;
  wire all_reset = cmd_fire & cmd_code == `ECCT_OP_RESET & cmd_arg[0];
  wire latch_fire = cmd_fire & cmd_code == `ECCT_OP_LATCH & sel_ok;
  wire [`ECCT_CW-1:0] sel_count = ch_count[sel[2:0]];

  // select, line function, latch; a full reset also empties the words
  // latch is a snapshot; the live count keeps moving behind it
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sel <= 8'h00;
      lfs <= `ECCT_LFS_RESET;
      latch <= '0;
    end else begin
      if (wr_en & w_idx == `ECCT_IDX_SEL) begin
        sel <= w_data[7:0];
      end
      if (wr_en & w_idx == `ECCT_IDX_LFS) begin
        lfs <= w_data[0];
      end
      if (all_reset) begin
        latch <= '0;
      end else if (latch_fire) begin
        latch <= sel_count;
      end
    end
  end

  // data word bytes, one writable byte per index
  // only lane zero counts, so wide writes cannot touch other bytes
  genvar b;
  generate
    for (b = 0; b < 4; b++) begin : g_byte
      always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
          data_word[8*b +: 8] <= 8'h00;
        end else if (all_reset) begin
          data_word[8*b +: 8] <= 8'h00;
        end else if (wr_en & w_idx == 3'(b)) begin
          data_word[8*b +: 8] <= w_data[7:0];
        end
      end
    end
  endgenerate

  // =====================================================
  // internal counting rates as one-cycle enables
  // both dividers free-run, so a new source starts mid-period
  logic [6:0] div_fast;
  logic [6:0] div_slow;
  wire tick_fast = div_fast == 7'(`ECCT_DIV_FAST - 1);
  wire tick_slow = div_slow == 7'(`ECCT_DIV_SLOW - 1);
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      div_fast <= 7'h00;
      div_slow <= 7'h00;
    end else begin
      div_fast <= tick_fast ? 7'h00 : div_fast + 7'h01;
      div_slow <= tick_slow ? 7'h00 : div_slow + 7'h01;
    end
  end

  // =====================================================
  // line synchronisers; the first stage is never looked at
  // reset high, matching the idle line, so no false edge after reset
  logic [`ECCT_NCH-1:0] pin_meta;
  logic [`ECCT_NCH-1:0] pin_sync;
  logic [`ECCT_NCH-1:0] pin_prev;
  wire [`ECCT_NCH-1:0] released = lfs ? `ECCT_HIGH_LINES : 8'h00;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pin_meta <= 8'hFF;
      pin_sync <= 8'hFF;
      pin_prev <= 8'hFF;
    end else begin
      pin_meta <= ctr_pin_in;
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  // =====================================================
  // channels and their line drive
  ecct_cmd_t            ch_cmd [`ECCT_NCH];
  logic [`ECCT_NCH-1:0] ext_fall;
  logic [`ECCT_NCH-1:0] next_oe;
  logic [`ECCT_NCH-1:0] next_dout;
  genvar i;
  generate
    for (i = 0; i < `ECCT_NCH; i++) begin : g_ch
      // a line lent to general i/o gives the counter no clock
      assign ext_fall[i] = pin_prev[i] & ~pin_sync[i] & ~released[i];
      assign ch_cmd[i].valid = cmd_fire &
        ((sel_ok & sel[2:0] == 3'(i)) | all_reset);
      assign ch_cmd[i].code = cmd_code;
      assign ch_cmd[i].arg = cmd_arg;
      assign ch_run[i] = ch_cfg[i].run;
      // external clock keeps the line an input, whatever else is set
      assign next_oe[i] = ch_cfg[i].out_en & ~released[i] &
        ch_cfg[i].src != `ECCT_SRC_EXT;
      // pulse is shown only while counting down
      assign next_dout[i] = ch_cfg[i].out_pol ^
        ~(ch_pulse[i] & ~ch_cfg[i].up);
      ecct_channel u_ch (
        .clock     (clock),
        .resetn    (resetn),
        .cmd       (ch_cmd[i]),
        .data_word (data_word),
        .ext_fall  (ext_fall[i]),
        .tick_fast (tick_fast),
        .tick_slow (tick_slow),
        .cfg       (ch_cfg[i]),
        .count     (ch_count[i]),
        .pulse     (ch_pulse[i])
      );
    end
  endgenerate

  // registered line drive; input role wins over output role
  // registered so the lines never see decode glitches
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pin_drive <= '0;
    end else begin
      pin_drive.oe <= next_oe;
      pin_drive.dout <= next_dout;
    end
  end

  // =====================================================
  // read channel: answer one cycle after the address is taken
  // the command register is write only and reads back zero
  wire ar_take = s_axi_arvalid & s_axi_arready;
  wire next_rvalid = ar_take | (s_axi_rvalid & ~s_axi_rready);
  wire [2:0] r_idx = s_axi_araddr[`ECCT_IDX_HI:`ECCT_IDX_LSB];
  wire r_mapped = s_axi_araddr[`ECCT_AW-1:`ECCT_IDX_HI+1] == '0;
  wire [7:0] latch_byte = 8'(latch >> {r_idx[1:0], 3'h0});
  wire [31:0] stat_word = {8'h00, pin_sync, pin_drive.oe, ch_run};
  wire [31:0] rd_word =
    r_idx <= `ECCT_IDX_DATA3 ? {24'h000000, latch_byte} :
    r_idx == `ECCT_IDX_SEL   ? {24'h000000, sel} :
    r_idx == `ECCT_IDX_LFS   ? {31'h00000000, lfs} :
    r_idx == `ECCT_IDX_STAT  ? stat_word : 32'h0000_0000;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `ECCT_RESP_OKAY;
    end else begin
      s_axi_arready <= ~next_rvalid;
      s_axi_rvalid <= next_rvalid;
      if (ar_take) begin
        s_axi_rdata <= r_mapped ? rd_word : 32'h0000_0000;
        s_axi_rresp <= r_mapped ? `ECCT_RESP_OKAY : `ECCT_RESP_SLVERR;
      end
    end
  end

  // =====================================================
  // checks
  // line checks watch counter 5, which the scenarios drive hardest; the external-input check watches counter 3, the release check lines 7-4
  AST_LATCH: assert property (@(posedge clock) disable iff (!resetn)
    latch_fire & ~all_reset |=> latch == $past(sel_count))
    else $error("latch did not capture the selected count");
  AST_INPUT_WINS: assert property(@(posedge clock) disable iff (!resetn)
    ch_cfg[5].src == `ECCT_SRC_EXT & ch_cfg[5].out_en
    |=> !pin_drive.oe[5])
    else $error("external clock line was driven");
  AST_OUT_DRIVE: assert property (@(posedge clock) disable iff (!resetn)
    ch_cfg[5].out_en & ch_cfg[5].src != `ECCT_SRC_EXT & ~lfs
    |=> pin_drive.oe[5])
    else $error("enabled output did not drive its line");
  AST_RELEASE: assert property (@(posedge clock) disable iff (!resetn)
    lfs |=> pin_drive.oe[7:4] == 4'h0)
    else $error("released line still driven by a counter");
  AST_RESET_ALL: assert property (@(posedge clock) disable iff (!resetn)
    all_reset |=> ch_run == 8'h00 && data_word == '0 ##1 ch_run == 8'h00)
    else $error("reset of all counters left state behind");
  AST_ONE_WRITE: assert property (@(posedge clock) disable iff (!resetn)
    do_write |=> s_axi_bvalid && !do_write)
    else $error("write not answered or executed twice");
  AST_SEL_WRITE: assert property (@(posedge clock) disable iff (!resetn)
    wr_en & w_idx == `ECCT_IDX_SEL
    |=> sel == $past(w_data[7:0]))
    else $error("select register missed its write");
  AST_SLVERR: assert property (@(posedge clock) disable iff (!resetn)
    do_write & ~w_mapped
    |=> s_axi_bresp == `ECCT_RESP_SLVERR)
    else $error("write outside the window was not refused");
  AST_RESET_ONE: assert property (@(posedge clock) disable iff (!resetn)
    cmd_fire & cmd_code == `ECCT_OP_RESET & sel_ok
    |=> sel_count == '0 && !ch_run[sel[2:0]])
    else $error("reset left the selected counter behind");
  AST_EXT_INPUT: assert property (@(posedge clock) disable iff (!resetn)
    ch_cfg[3].src == `ECCT_SRC_EXT
    |=> !pin_drive.oe[3])
    else $error("external clock line was turned to output");
  AST_PULSE_POL: assert property (@(posedge clock) disable iff (!resetn)
    ch_pulse[5] & ~ch_cfg[5].up
    |=> pin_drive.dout[5] == $past(ch_cfg[5].out_pol))
    else $error("zero pulse shown at the wrong level");
  AST_UP_IDLE: assert property (@(posedge clock) disable iff (!resetn)
    ch_cfg[5].up
    |=> pin_drive.dout[5] == !$past(ch_cfg[5].out_pol))
    else $error("up counter showed a pulse on its line");
  COV_LATCH_READ: cover property (@(posedge clock) disable iff (!resetn)
    latch_fire ##[1:20] (ar_take & r_idx == 3'h0));
  COV_RELOAD: cover property (@(posedge clock) disable iff (!resetn)
    ch_pulse[0] & ch_cfg[0].reload_en & ch_cfg[0].run);
  COV_OUT_PULSE: cover property (@(posedge clock) disable iff (!resetn)
    pin_drive.oe[2] & $changed(pin_drive.dout[2]));
  COV_REFUSED: cover property (@(posedge clock) disable iff (!resetn)
    do_write & ~w_mapped);
  COV_RESET_ALL: cover property (@(posedge clock) disable iff (!resetn)
    all_reset);
endmodule

// File: testbench/ecct_bank_tb.sv
// self-checking bench for the eight-channel counter/timer bank
`timescale 1ns/100ps
module ecct_bank_tb;
  import ecct_pkg::*;
  // ==========================================================
  // design ports
  logic        clock;
  logic        resetn;
  logic [7:0]  s_axi_awaddr;
  logic        s_axi_awvalid;
  logic        s_axi_awready;
  logic [31:0] s_axi_wdata;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_wvalid;
  logic        s_axi_wready;
  logic [1:0]  s_axi_bresp;
  logic        s_axi_bvalid;
  logic        s_axi_bready;
  logic [7:0]  s_axi_araddr;
  logic        s_axi_arvalid;
  logic        s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_rresp;
  logic        s_axi_rvalid;
  logic        s_axi_rready;
  logic [7:0]  ctr_pin_in;
  ecct_pins_t  pin_drive;
  // bench state: notes of expected answers, counters, random source
  logic [1:0]  exp_b[$];
  logic [33:0] exp_r[$];
  int          n_fail;
  int          tests_run;
  logic [31:0] rnd;
  logic [31:0] val;

  ecct_bank i_dut (.clock(clock), .resetn(resetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .ctr_pin_in(ctr_pin_in),
    .pin_drive(pin_drive));

  // 100 MHz clock
  always #5 clock = ~clock;

  // ==========================================================
  // reporting
  task automatic end_sim();
    $display("comparisons %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic tally(input logic ok, input string what);
    tests_run++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("wrong value at %0t ns: %s", $time, what);
    end
  endtask
  task automatic hang();
    tally(1'b0, "wait ran out");
    end_sim();
  endtask
  task automatic check_b(input logic [1:0] got, input logic [1:0] exp);
    tally(got === exp, $sformatf("bresp %h not %h", got, exp));
  endtask
  task automatic check_r(input logic [33:0] got, input logic [33:0] exp);
    tally(got === exp, $sformatf("read %h not %h", got, exp));
  endtask
  task automatic check_pin(input logic got, input logic exp);
    tally(got === exp, $sformatf("line level %b not %b", got, exp));
  endtask

  // answer watcher: each answer against the oldest note
  always @(posedge clock) begin
    if (resetn && s_axi_bvalid && s_axi_bready) begin
      if (exp_b.size() == 0) tally(1'b0, "write answer not asked for");
      else check_b(s_axi_bresp, exp_b.pop_front());
    end
    if (resetn && s_axi_rvalid && s_axi_rready) begin
      if (exp_r.size() == 0) tally(1'b0, "read answer not asked for");
      else check_r({s_axi_rdata, s_axi_rresp}, exp_r.pop_front());
    end
  end

  // ==========================================================
  // bus master and stimulus helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // ready lines are registered, so they are looked at on the edge
  task automatic wr(input logic [7:0] addr, input logic [7:0] data,
                    input logic [1:0] resp);
    int k;
    exp_b.push_back(resp);
    rnd = lfsr(rnd);
    s_axi_awaddr  <= addr;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= {rnd[31:8], data}; // upper lanes must be ignored
    s_axi_wvalid  <= 1'b1;
    for (k = 0; k < 64; k++) begin
      @(posedge clock);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    if (k == 64) hang();
  endtask
  task automatic rd(input logic [7:0] addr, input logic [31:0] data,
                    input logic [1:0] resp);
    int k;
    exp_r.push_back({data, resp});
    s_axi_araddr  <= addr;
    s_axi_arvalid <= 1'b1;
    for (k = 0; k < 64; k++) begin
      @(posedge clock);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    if (k == 64) hang();
  endtask
  task automatic cmd(input logic [7:0] c);
    wr(8'h14, c, 2'h0);
  endtask
  task automatic sel(input logic [7:0] ch);
    wr(8'h10, ch, 2'h0);
  endtask
  task automatic load32(input logic [31:0] v);
    for (int b = 0; b < 4; b++) wr(8'(4 * b), v[8 * b +: 8], 2'h0);
    cmd(8'h10);
  endtask
  task automatic expect_count(input logic [31:0] v);
    cmd(8'h50);
    for (int b = 0; b < 4; b++) rd(8'(4 * b), {24'h0, v[8 * b +: 8]}, 2'h0);
  endtask
  // falling edges on one line; held long enough for the syncs
  task automatic ext_ticks(input int ch, input int n);
    for (int i = 0; i < n; i++) begin
      ctr_pin_in[ch] <= 1'b0;
      repeat (4) @(posedge clock);
      ctr_pin_in[ch] <= 1'b1;
      repeat (4) @(posedge clock);
    end
  endtask
  // counter 5 from reload 4 at fast rate: 2 cycles active, 6 idle
  task automatic watch_pulse(input logic idle);
    int k;
    // start from the idle level so a pulse already under way is skipped
    for (k = 0; k < 40; k++) begin
      @(posedge clock);
      if (pin_drive.dout[5] === idle) break;
    end
    for (; k < 40; k++) begin
      @(posedge clock);
      if (pin_drive.dout[5] === ~idle) break;
    end
    if (k == 40) hang();
    for (k = 1; k < 8; k++) begin
      @(posedge clock);
      check_pin(pin_drive.dout[5], (k < 2) ? ~idle : idle);
    end
  endtask

  // ==========================================================
  // main sequence
  initial begin
    clock = 1'b0;
    resetn = 1'b0;
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid} = '0;
    {s_axi_araddr, s_axi_arvalid} = '0;
    s_axi_wstrb = 4'hF;
    s_axi_bready = 1'b1; // answers are always accepted at once
    s_axi_rready = 1'b1;
    ctr_pin_in = 8'hFF;
    n_fail = 0;
    tests_run = 0;
    rnd = 32'd48;
    repeat (8) @(posedge clock);
    resetn <= 1'b1;
    repeat (2) @(posedge clock);
    // reset state, unmapped space, refused byte lane
    rd(8'h10, 32'h0, 2'h0);
    rd(8'h1C, 32'h00FF0000, 2'h0);
    rd(8'h20, 32'h0, 2'h2);
    wr(8'h24, 8'h5A, 2'h2);
    s_axi_wstrb <= 4'h0;
    wr(8'h10, 8'h06, 2'h0);
    s_axi_wstrb <= 4'hF;
    rd(8'h10, 32'h0, 2'h0);
    // load, latch and down counting on the external line
    rnd = lfsr(rnd);
    val = {rnd[31:4], 4'hA};
    sel(8'h03);
    rd(8'h10, 32'h3, 2'h0);
    load32(val);
    expect_count(val);
    rd(8'h14, 32'h0, 2'h0);
    cmd(8'h41);
    ext_ticks(3, 3);
    expect_count(val - 3);
    rd(8'h1C, 32'h00FF0008, 2'h0);
    cmd(8'h40);
    ext_ticks(3, 2);
    expect_count(val - 3);
    cmd(8'h41);
    cmd(8'h31);
    ext_ticks(3, 1);
    expect_count(val - 4);
    cmd(8'h00);
    expect_count(val);
    ext_ticks(3, 1);
    expect_count(val - 1);
    // up counting after clear
    cmd(8'h21);
    cmd(8'h00);
    expect_count(32'h0);
    ext_ticks(3, 2);
    expect_count(32'h2);
    // other counters untouched; auto-reload on and off
    sel(8'h04);
    expect_count(32'h0);
    load32(32'h2);
    cmd(8'h71);
    cmd(8'h41);
    ext_ticks(4, 2);
    expect_count(32'h2);
    cmd(8'h70);
    ext_ticks(4, 3);
    expect_count(32'h0);
    // single reset against reset of all counters
    load32(val);
    sel(8'h03);
    cmd(8'hF0);
    expect_count(32'h0);
    sel(8'h04);
    expect_count(val);
    cmd(8'hF1);
    expect_count(32'h0);
    // output pulse, polarity, line ownership
    sel(8'h05);
    load32(32'h4);
    cmd(8'h71);
    cmd(8'h62);
    cmd(8'h82);
    cmd(8'h41);
    rd(8'h1C, 32'h00FF2020, 2'h0);
    watch_pulse(1'b1);
    cmd(8'h83);
    watch_pulse(1'b0);
    cmd(8'h21);
    repeat (20) begin
      @(posedge clock);
      check_pin(pin_drive.dout[5], 1'b0);
    end
    wr(8'h18, 8'h01, 2'h0);
    rd(8'h1C, 32'h00FF0020, 2'h0);
    wr(8'h18, 8'h00, 2'h0);
    rd(8'h1C, 32'h00FF2020, 2'h0);
    cmd(8'h60);
    rd(8'h1C, 32'h00FF0020, 2'h0);
    repeat (4) @(posedge clock);
    end_sim();
  end
endmodule
